// ===== design/usb_cmd_device.sv
// Decided for this implementation: the address map and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "usb_cmd_params.svh"
module usb_cmd_device #(
  parameter int unsigned MS_CYCLES       = `MS_CYCLES,
  // Arbitrary identity values.
  parameter logic [7:0]  CHIP_CODE       = 8'h5A,
  parameter logic [7:0]  SILICON_VERSION = 8'h12
) (
  // Clock and reset.
  input  wire logic                    mclk_i,
  input  wire logic                    rst_n_i,
  // Command link.
  usb_cmd_if.dev                       link,
  // USB engine events.
  input  wire logic                    sof_i,
  input  wire logic [`FRAME_W-1:0]     sof_frame_i,
  input  wire logic                    bus_reset_i,
  input  wire logic                    resume_i,
  input  wire logic                    eot_i,
  input  wire logic                    short_eot_i,
  input  wire logic [15:0]             ep_event_i,
  input  wire logic [`SRC_W-1:0]       int_enable_i,
  // Status.
  output logic                         irq_o,
  output logic                         suspended_o,
  output logic                         locked_o
);
  import usb_cmd_pkg::*;

  // **********************************************************************
  // State
  // **********************************************************************
  logic [7:0]          cmd_r,       cmd_nxt;
  logic                idx_r,       idx_nxt;
  logic [`SCRATCH_W-1:0] scratch_r, scratch_nxt;
  logic [`FRAME_W-1:0] frame_r,     frame_nxt;
  logic [`SRC_W-1:0]   flags_r,     flags_nxt;
  logic                susp_r,      susp_nxt;
  logic                lock_r,      lock_nxt;
  logic [31:0]         ms_cnt_r,    ms_cnt_nxt;
  logic [1:0]          missed_r,    missed_nxt;
  word_t               dev_d_r,     dev_d_nxt;
  logic                dev_oe_r,    dev_oe_nxt;
  logic                irq_r,       irq_nxt;

  logic                cmd_wr;
  logic                data_wr;
  logic                tick;
  logic                enter_susp;
  logic [`SRC_W-1:0]   set_v;
  logic [`SRC_W-1:0]   clr_v;
  word_t               rd_word;

  // **********************************************************************
  // Read data selection
  // **********************************************************************
  always_comb begin
    rd_word = 16'h0000;
    if (!lock_r) begin
      unique case (cmd_r)
        `CMD_SCRATCH_RD: rd_word = {3'b000, scratch_r};
        `CMD_FRAME_RD:   rd_word = {5'b00000, frame_r};
        `CMD_IDENT_RD:   rd_word = {CHIP_CODE, SILICON_VERSION};
        `CMD_INTSRC_RD: begin
          if (idx_r) begin
            rd_word = {8'h00, flags_r[23:16]};
          end else begin
            rd_word = {flags_r[15:8], susp_r, flags_r[6:0]};
          end
        end
        default:         rd_word = 16'h0000;
      endcase
    end
  end

  // **********************************************************************
  // Next state
  // **********************************************************************
  always_comb begin
    cmd_wr      = link.wr && link.addr_sel;
    data_wr     = link.wr && !link.addr_sel;
    cmd_nxt     = cmd_r;
    idx_nxt     = idx_r;
    scratch_nxt = scratch_r;
    frame_nxt   = frame_r;
    susp_nxt    = susp_r;
    lock_nxt    = lock_r;
    missed_nxt  = missed_r;
    dev_d_nxt   = dev_d_r;
    dev_oe_nxt  = 1'b0;
    set_v       = '0;
    clr_v       = '0;
    tick        = 1'b0;
    enter_susp  = 1'b0;

    // Command phase takes the low byte only.
    if (cmd_wr) begin
      cmd_nxt = link.bus_d[7:0];
      idx_nxt = 1'b0;
    end

    // Data phase writes.
    if (data_wr) begin
      if (cmd_r == `CMD_UNLOCK) begin
        if (link.bus_d == `UNLOCK_KEY) begin
          lock_nxt = 1'b0;
        end
      end else if (cmd_r == `CMD_SCRATCH_WR && !lock_r) begin
        scratch_nxt = link.bus_d[`SCRATCH_W-1:0];
      end
    end

    // Data phase reads answer one cycle later.
    if (link.rd && !link.addr_sel) begin
      dev_d_nxt  = rd_word;
      dev_oe_nxt = 1'b1;
      idx_nxt    = ~idx_r;
      if (cmd_r == `CMD_INTSRC_RD && idx_r && !lock_r) begin
        clr_v = '1;
      end
    end

    // Millisecond watch on start-of-frame packets.
    if (sof_i || bus_reset_i) begin
      ms_cnt_nxt = '0;
      missed_nxt = 2'h0;
    end else if (ms_cnt_r >= MS_CYCLES - 1) begin
      ms_cnt_nxt = '0;
      tick       = 1'b1;
      if (!susp_r) begin
        missed_nxt = missed_r + 2'h1;
        if (missed_r + 2'h1 == `MISSED_LIMIT) begin
          enter_susp = 1'b1;
          missed_nxt = 2'h0;
        end
      end
    end else begin
      ms_cnt_nxt = ms_cnt_r + 32'd1;
    end

    if (sof_i) begin
      frame_nxt = sof_frame_i;
    end
    // Frame number is left as is on bus reset.
    if (enter_susp) begin
      susp_nxt = 1'b1;
      lock_nxt = 1'b1;
    end else if (resume_i || sof_i || bus_reset_i) begin
      susp_nxt = 1'b0;
    end

    // Event flags: set wins over clear.
    set_v[23:8]             = ep_event_i;
    set_v[`BIT_SHORT_EOT]   = short_eot_i;
    set_v[`BIT_PSEUDO_TICK] = tick;
    set_v[`BIT_FRAME_SEEN]  = sof_i;
    set_v[`BIT_EOT]         = eot_i;
    set_v[`BIT_SUSP_ENTRY]  = enter_susp;
    set_v[`BIT_RESUME]      = resume_i;
    set_v[`BIT_BUS_RESET]   = bus_reset_i;
    flags_nxt = (flags_r & ~clr_v) | set_v;
    flags_nxt[`BIT_BUS_STATE] = 1'b0;
    irq_nxt = |(flags_r & int_enable_i);
  end

  // **********************************************************************
  // Registers
  // **********************************************************************
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_r     <= 8'h00;
      idx_r     <= 1'b0;
      scratch_r <= '0;
      frame_r   <= '0;
      flags_r   <= '0;
      susp_r    <= 1'b0;
      lock_r    <= 1'b0;
      ms_cnt_r  <= '0;
      missed_r  <= 2'h0;
      dev_d_r   <= 16'h0000;
      dev_oe_r  <= 1'b0;
      irq_r     <= 1'b0;
    end else begin
      cmd_r     <= cmd_nxt;
      idx_r     <= idx_nxt;
      scratch_r <= scratch_nxt;
      frame_r   <= frame_nxt;
      flags_r   <= flags_nxt;
      susp_r    <= susp_nxt;
      lock_r    <= lock_nxt;
      ms_cnt_r  <= ms_cnt_nxt;
      missed_r  <= missed_nxt;
      dev_d_r   <= dev_d_nxt;
      dev_oe_r  <= dev_oe_nxt;
      irq_r     <= irq_nxt;
    end
  end

  assign link.dev_d  = dev_d_r;
  assign link.dev_oe = dev_oe_r;
  assign irq_o       = irq_r;
  assign suspended_o = susp_r;
  assign locked_o    = lock_r;
endmodule : usb_cmd_device
`default_nettype wire

// ===== design/usb_cmd_host.sv
`timescale 1ns/100ps
`default_nettype none
`include "usb_cmd_params.svh"
module usb_cmd_host (
  // Clock and reset.
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // AHB-Lite slave.
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Command link.
  usb_cmd_if.host          link
);
  import usb_cmd_pkg::*;

  // **********************************************************************
  // State
  // **********************************************************************
  host_state_t state_r,  state_nxt;
  logic        wpend_r,  wpend_nxt;
  logic [3:0]  waddr_r,  waddr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  word_t       rdata_r,  rdata_nxt;
  word_t       d_r,      d_nxt;
  logic        oe_r,     oe_nxt;
  logic        sel_r,    sel_nxt;
  logic        wr_r,     wr_nxt;
  logic        rd_r,     rd_nxt;
  logic        addr_ph;

  // **********************************************************************
  // Next state
  // **********************************************************************
  always_comb begin
    addr_ph    = hsel_i && htrans_i[1] && hready_i;
    state_nxt  = state_r;
    wpend_nxt  = addr_ph && hwrite_i;
    waddr_nxt  = addr_ph ? haddr_i[3:0] : waddr_r;
    hrdata_nxt = 32'h0000_0000;
    rdata_nxt  = rdata_r;
    d_nxt      = d_r;
    oe_nxt     = 1'b0;
    sel_nxt    = sel_r;
    wr_nxt     = 1'b0;
    rd_nxt     = 1'b0;

    if (addr_ph && !hwrite_i) begin
      unique case (haddr_i[3:0])
        `OFF_STATUS: hrdata_nxt = {31'h0, state_r != H_IDLE};
        `OFF_RDATA:  hrdata_nxt = {16'h0000, rdata_r};
        default:     hrdata_nxt = 32'h0000_0000;
      endcase
    end

    unique case (state_r)
      H_IDLE: begin
        if (wpend_r && waddr_r == `OFF_OP) begin
          unique case (hwdata_i[17:16])
            `OP_CMD: begin
              d_nxt     = {8'h00, hwdata_i[7:0]};
              sel_nxt   = 1'b1;
              oe_nxt    = 1'b1;
              wr_nxt    = 1'b1;
              state_nxt = H_WRITE;
            end
            `OP_WRITE: begin
              d_nxt     = hwdata_i[15:0];
              sel_nxt   = 1'b0;
              oe_nxt    = 1'b1;
              wr_nxt    = 1'b1;
              state_nxt = H_WRITE;
            end
            `OP_READ: begin
              sel_nxt   = 1'b0;
              rd_nxt    = 1'b1;
              state_nxt = H_RD_REQ;
            end
            `OP_UNLOCK: begin
              d_nxt     = {8'h00, `CMD_UNLOCK};
              sel_nxt   = 1'b1;
              oe_nxt    = 1'b1;
              wr_nxt    = 1'b1;
              state_nxt = H_KEY;
            end
          endcase
        end
      end
      H_KEY: begin
        d_nxt     = `UNLOCK_KEY;
        sel_nxt   = 1'b0;
        oe_nxt    = 1'b1;
        wr_nxt    = 1'b1;
        state_nxt = H_WRITE;
      end
      H_WRITE:  state_nxt = H_IDLE;
      H_RD_REQ: state_nxt = H_RD_CAP;
      H_RD_CAP: begin
        rdata_nxt = link.bus_d;
        state_nxt = H_IDLE;
      end
      default:  state_nxt = H_IDLE;
    endcase
  end

  // **********************************************************************
  // Registers
  // **********************************************************************
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r  <= H_IDLE;
      wpend_r  <= 1'b0;
      waddr_r  <= 4'h0;
      hrdata_r <= 32'h0000_0000;
      rdata_r  <= 16'h0000;
      d_r      <= 16'h0000;
      oe_r     <= 1'b0;
      sel_r    <= 1'b0;
      wr_r     <= 1'b0;
      rd_r     <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      wpend_r  <= wpend_nxt;
      waddr_r  <= waddr_nxt;
      hrdata_r <= hrdata_nxt;
      rdata_r  <= rdata_nxt;
      d_r      <= d_nxt;
      oe_r     <= oe_nxt;
      sel_r    <= sel_nxt;
      wr_r     <= wr_nxt;
      rd_r     <= rd_nxt;
    end
  end

  assign hrdata_o      = hrdata_r;
  assign hreadyout_o   = 1'b1;
  assign hresp_o       = 1'b0;
  assign link.host_d   = d_r;
  assign link.host_oe  = oe_r;
  assign link.addr_sel = sel_r;
  assign link.wr       = wr_r;
  assign link.rd       = rd_r;
endmodule : usb_cmd_host
`default_nettype wire

// ===== pkg/usb_cmd_if.sv
`timescale 1ns/100ps
`default_nettype none
interface usb_cmd_if;
  import usb_cmd_pkg::*;
  word_t host_d;
  logic  host_oe;
  logic  addr_sel;
  logic  wr;
  logic  rd;
  word_t dev_d;
  logic  dev_oe;
  word_t bus_d;

  // Resolves the shared data lines; pull-ups give all ones when undriven.
  assign bus_d = host_oe ? host_d : (dev_oe ? dev_d : 16'hFFFF);

  modport dev  (input addr_sel, wr, rd, bus_d, output dev_d, dev_oe);
  modport host (output host_d, host_oe, addr_sel, wr, rd, input bus_d);
endinterface : usb_cmd_if
`default_nettype wire

// ===== pkg/usb_cmd_params.svh
// Functional notes
// - Key AA37H via unlock command lifts protection
// - Suspended device blocks writes and reads
// - Byte-wide host sends key low byte first
// - Scratch word: B2H writes, B3H reads
// - Scratch bits 12..0 stored; upper written zero
// - B4H returns last received frame number
// - Frame read one word; bits 10..0
// - Frame resets zero; bus reset leaves undefined
// - Select high: command byte; low: data word
// - B5H returns chip code and version
// - Firmware uses identity word for features
// - C0H returns 32-bit sources, top byte reserved
// - Host reads both source words completely
// - Per-endpoint flags, gated by enable mask
// - Bits 23..10 endpoints, 9 IN, 8 OUT
// - Bit 7 shows live suspend state
// - Bit 6 flags short end of transfer
// - Bits 5..0 tick,frame,eot,suspend,resume,reset
// - Tick each millisecond; suspend after three misses
`ifndef USB_CMD_PARAMS_SVH
`define USB_CMD_PARAMS_SVH

`define CMD_UNLOCK      8'hB0
`define CMD_SCRATCH_WR  8'hB2
`define CMD_SCRATCH_RD  8'hB3
`define CMD_FRAME_RD    8'hB4
`define CMD_IDENT_RD    8'hB5
`define CMD_INTSRC_RD   8'hC0
`define UNLOCK_KEY      16'hAA37
`define BUS_IDLE_WORD   16'hFFFF

`define SCRATCH_W       13
`define FRAME_W         11
`define SRC_W           24
`define BIT_BUS_STATE   7
`define BIT_SHORT_EOT   6
`define BIT_PSEUDO_TICK 5
`define BIT_FRAME_SEEN  4
`define BIT_EOT         3
`define BIT_SUSP_ENTRY  2
`define BIT_RESUME      1
`define BIT_BUS_RESET   0
`define MISSED_LIMIT    2'h3

`define MS_TIME_NS      1000000
`define CLK_PERIOD_NS   5
`define MS_CYCLES       (`MS_TIME_NS / `CLK_PERIOD_NS)

`define OFF_OP          4'h0
`define OFF_STATUS      4'h4
`define OFF_RDATA       4'h8
`define OP_CMD          2'h0
`define OP_WRITE        2'h1
`define OP_READ         2'h2
`define OP_UNLOCK       2'h3

`endif

// ===== pkg/usb_cmd_pkg.sv
`default_nettype none
package usb_cmd_pkg;
  typedef logic [15:0] word_t;
  typedef enum logic [2:0] {
    H_IDLE   = 3'b000,
    H_WRITE  = 3'b001,
    H_RD_REQ = 3'b010,
    H_RD_CAP = 3'b011,
    H_KEY    = 3'b100
  } host_state_t;
endpackage : usb_cmd_pkg
`default_nettype wire

// ===== sim/tb_usb_device_general_command_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "usb_cmd_params.svh"
module tb_usb_device_general_command_regs;
  import usb_cmd_pkg::*;
  // Arbitrary identity values.
  localparam word_t IDENT = 16'hC321;
  logic        mclk_i    = 1'h0;
  logic        rst_n_i   = 1'h0;
  logic        hsel      = 1'h0;
  logic        hwrite    = 1'h0;
  logic [1:0]  htrans    = 2'h0;
  logic [2:0]  hsize     = 3'h2;
  logic [31:0] haddr     = 32'h0;
  logic [31:0] hwdata    = 32'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        sof       = 1'h0;
  logic        bus_rst   = 1'h0;
  logic        resume    = 1'h0;
  logic        end_of_transfer_flag       = 1'h0;
  logic        short_eot = 1'h0;
  logic [10:0] frame     = 11'h0;
  word_t       ep_ev     = 16'h0;
  logic [23:0] int_en    = 24'h0;
  logic        irq;
  logic        susp;
  logic        locked;
  int          n_fail    = 0;
  int          n_tests   = 0;
  word_t       exp_q[$];

  usb_cmd_if link ();
  usb_cmd_device #(
    .MS_CYCLES(1000), .CHIP_CODE(IDENT[15:8]), .SILICON_VERSION(IDENT[7:0])
  ) i_usb_cmd_device (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(link), .sof_i(sof),
    .sof_frame_i(frame), .bus_reset_i(bus_rst), .resume_i(resume),
    .eot_i(end_of_transfer_flag), .short_eot_i(short_eot), .ep_event_i(ep_ev),
    .int_enable_i(int_en), .irq_o(irq), .suspended_o(susp),
    .locked_o(locked)
  );
  usb_cmd_host i_usb_cmd_host (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .link(link)
  );
  usb_cmd_assertions i_usb_cmd_assertions (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .host_d(link.host_d),
    .host_oe(link.host_oe), .addr_sel(link.addr_sel), .wr(link.wr),
    .rd(link.rd), .dev_d(link.dev_d), .dev_oe(link.dev_oe)
  );

  always #2.5 mclk_i = !mclk_i;

  // ****************
  // Bus and checking tasks.
  // ****************
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic ahb(input logic w, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do @(posedge mclk_i); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk_i); while (hready !== 1'h1);
    r = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : ahb

  task automatic op(input logic [1:0] k, input word_t d);
    logic [31:0] r;
    ahb(1'h1, {28'h0, `OFF_OP}, {14'h0, k, d}, r);
    ahb(1'h0, {28'h0, `OFF_STATUS}, 32'h0, r);
    for (int i = 0; i < 20; i++) begin
      ahb(1'h0, {28'h0, `OFF_STATUS}, 32'h0, r);
      if (r[0] === 1'h0) break;
    end
  endtask : op

  task automatic rdw(input logic [7:0] c, input word_t e);
    op(`OP_CMD, {8'h00, c});
    exp_q.push_back(e);
    op(`OP_READ, 16'h0000);
  endtask : rdw

  task automatic ev(input logic [4:0] k, input word_t ep,
                    input logic [10:0] f);
    {sof, bus_rst, resume, end_of_transfer_flag, short_eot} <= k;
    ep_ev <= ep;
    frame <= f;
    @(posedge mclk_i);
    {sof, bus_rst, resume, end_of_transfer_flag, short_eot} <= 5'h00;
    ep_ev <= 16'h0000;
    @(posedge mclk_i);
  endtask : ev

  task automatic report_and_stop();
    if (n_fail == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge mclk_i) begin
    if (rst_n_i && link.dev_oe === 1'h1) begin
      if (exp_q.size() == 0) chk("stray read", 32'h0, 32'h1);
      else chk("read word", exp_q.pop_front(), link.bus_d);
    end
  end

  initial begin
    repeat (20000) @(posedge mclk_i);
    n_fail++;
    report_and_stop();
  end

  // ****************
  // Stimulus.
  // ****************
  initial begin
    logic [31:0] r;
    word_t       v;
    word_t       ep;
    logic [10:0] f;
    r = $urandom(60422);
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'h1;
    @(posedge mclk_i);
    rdw(`CMD_IDENT_RD, IDENT);
    rdw(`CMD_IDENT_RD, IDENT);
    ahb(1'h0, 32'hC, 32'h0, r);
    chk("unmapped", 32'h0, r);
    rdw(`CMD_SCRATCH_RD, 16'h0000);
    for (int i = 0; i < 2; i++) begin
      v = (i == 0) ? 16'h1FFF : (16'($urandom) & 16'h1FFF);
      op(`OP_CMD, {8'h00, `CMD_SCRATCH_WR});
      op(`OP_WRITE, v);
      rdw(`CMD_SCRATCH_RD, v);
    end
    rdw(`CMD_FRAME_RD, 16'h0000);
    f = 11'($urandom);
    ev(5'h10, 16'h0000, f);
    rdw(`CMD_FRAME_RD, {5'h00, f});
    ep = 16'($urandom);
    ev(5'h1F, ep, f);
    repeat (2) @(posedge mclk_i);
    chk("masked irq", 32'h0, irq);
    int_en <= 24'hFFFFFF;
    repeat (2) @(posedge mclk_i);
    chk("irq", 32'h1, irq);
    rdw(`CMD_INTSRC_RD, {ep[7:0], 8'h5B});
    exp_q.push_back({8'h00, ep[15:8]});
    op(`OP_READ, 16'h0000);
    rdw(`CMD_INTSRC_RD, 16'h0000);
    exp_q.push_back(16'h0000);
    op(`OP_READ, 16'h0000);
    chk("irq cleared", 32'h0, irq);
    repeat (3100) @(posedge mclk_i);
    chk("suspended", 32'h1, susp);
    chk("locked", 32'h1, locked);
    rdw(`CMD_IDENT_RD, 16'h0000);
    op(`OP_CMD, {8'h00, `CMD_SCRATCH_WR});
    op(`OP_WRITE, 16'h0AAA);
    op(`OP_CMD, {8'h00, `CMD_UNLOCK});
    op(`OP_WRITE, 16'hAA36);
    ev(5'h04, 16'h0000, f);
    chk("locked after resume", 32'h1, locked);
    chk("awake", 32'h0, susp);
    f = 11'h7FF;
    ev(5'h10, 16'h0000, f);
    rdw(`CMD_IDENT_RD, 16'h0000);
    op(`OP_UNLOCK, 16'h0000);
    chk("unlocked", 32'h0, locked);
    rdw(`CMD_IDENT_RD, IDENT);
    rdw(`CMD_SCRATCH_RD, v);
    rdw(`CMD_FRAME_RD, 16'h07FF);
    rdw(`CMD_INTSRC_RD, 16'h0036);
    exp_q.push_back(16'h0000);
    op(`OP_READ, 16'h0000);
    chk("pending reads", 32'h0, exp_q.size());
    report_and_stop();
  end
endmodule : tb_usb_device_general_command_regs
`default_nettype wire

// ===== sim/usb_cmd_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "usb_cmd_params.svh"
module usb_cmd_assertions
  import usb_cmd_pkg::*;
(
  // Clock and reset.
  input  wire logic  mclk_i,
  input  wire logic  rst_n_i,
  // Link signals.
  input  wire word_t host_d,
  input  wire logic  host_oe,
  input  wire logic  addr_sel,
  input  wire logic  wr,
  input  wire logic  rd,
  input  wire word_t dev_d,
  input  wire logic  dev_oe
);
  logic [7:0] cmd_r;
  logic [7:0] cmd_nxt;
  logic       idx_r;
  logic       idx_nxt;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // ****************
  // Helper state.
  // ****************
  always_comb begin
    cmd_nxt = cmd_r;
    idx_nxt = idx_r;
    if (wr && addr_sel) begin
      cmd_nxt = host_d[7:0];
      idx_nxt = 1'h0;
    end else if (dev_oe) begin
      idx_nxt = !idx_r;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_r <= 8'h00;
      idx_r <= 1'h0;
    end else begin
      cmd_r <= cmd_nxt;
      idx_r <= idx_nxt;
    end
  end

  // ****************
  // Checks.
  // ****************
  rd_answer_a: assert property (rd |=> dev_oe && !host_oe)
    else $error("read not answered");
  answer_cause_a: assert property (dev_oe |-> $past(rd))
    else $error("device drove unasked");
  no_clash_a: assert property (!(host_oe && dev_oe))
    else $error("both ends drive");
  rd_phase_a: assert property (rd |-> !addr_sel && !host_oe)
    else $error("read outside data phase");
  cmd_byte_a: assert property (
    wr && addr_sel |-> host_d[15:8] == 8'h00)
    else $error("command high byte not zero");
  wr_pulse_a: assert property (
    wr |-> host_oe ##1 (!wr || (!addr_sel && $past(addr_sel))))
    else $error("write strobe too long");
  rd_gap_a: assert property (rd |=> !rd [*2])
    else $error("reads too close");
  scratch_res_a: assert property (dev_oe && cmd_r == `CMD_SCRATCH_RD
    |-> dev_d[15:13] == 3'h0)
    else $error("scratch reserved bits set");
  frame_res_a: assert property (dev_oe && cmd_r == `CMD_FRAME_RD
    |-> dev_d[15:11] == 5'h00)
    else $error("frame reserved bits set");
  src_top_a: assert property (dev_oe && cmd_r == `CMD_INTSRC_RD
    && idx_r |-> dev_d[15:8] == 8'h00)
    else $error("source top byte set");

  key_seen_c: cover property (wr && !addr_sel && host_d == `UNLOCK_KEY);
  ident_read_c: cover property (dev_oe && cmd_r == `CMD_IDENT_RD);
  src_pair_c: cover property (dev_oe && cmd_r == `CMD_INTSRC_RD && idx_r);
endmodule : usb_cmd_assertions
`default_nettype wire
